// File: shared/tosm_consts.svh
// Purpose: Constants for the one-shot and monostable timer mode block.
// Assumes: Included by bare name from design files.
// Notes: Mode codes are the 5-bit mode field values.
`ifndef TOSM_CONSTS_SVH
`define TOSM_CONSTS_SVH
`define TOSM_MODE_OS_RISE 5'h09
`define TOSM_MODE_OS_FALL 5'h0A
`define TOSM_MODE_OS_ANY 5'h0B
`define TOSM_MODE_HL_RISE 5'h0C
`define TOSM_MODE_HL_FALL 5'h0D
`define TOSM_MODE_LR_LOW 5'h0E
`define TOSM_MODE_LR_HIGH 5'h0F
`define TOSM_MODE_MS_RISE 5'h11
`define TOSM_MODE_MS_FALL 5'h12
`define TOSM_MODE_MS_ANY 5'h13
`define TOSM_RESTART_DELAY 2
`define TOSM_COUNT_RESET 8'h00
`endif

// File: shared/tosm_pkg.sv
// Purpose: Types for the one-shot and monostable timer mode block.
// Assumes: Nothing.
// Notes: Mode classes group the mode field codes.
package tosm_pkg;
  typedef enum logic [2:0]
  {
    TOSM_CLS_NONE = 3'b000,
    TOSM_CLS_OS = 3'b001,
    TOSM_CLS_HL = 3'b010,
    TOSM_CLS_LR = 3'b011,
    TOSM_CLS_MS = 3'b100
  } tosm_cls_e;
  typedef logic [4:0] tosm_mode_t;
endpackage

// File: tb/testbench.sv
// Purpose: Self-checking bench for the triggered one-shot timer modes.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Waits are bounded so a stuck design fails instead of hanging.
`timescale 1ns/1ns
`include "tosm_consts.svh"
module testbench;
  import tosm_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic runSet = 0;
  logic runClr = 0;
  logic want = 0;
  logic pwmClr = 1;
  tosm_mode_t mode = 5'h00;
  logic [7:0] per = 8'h05;
  logic [7:0] pw = 8'h03;
  logic sig;
  logic runBit;
  logic pwmDrive;
  logic counting;
  logic [7:0] counterValue;
  logic [7:0] pwmHigh;
  int n_fail = 0;
  int compares = 0;

  // ----------------------------------------
  // Clock, design and far side
  // ----------------------------------------
  always #50 clk = ~clk;

  tosm_timer #(.WIDTH(8)) dut_u (.clk(clk), .rst(rst), .runSet(runSet), .runClr(runClr),
    .mode(mode), .periodValue(per), .pulseWidthValue(pw), .extStartResetSignal(sig),
    .runBit(runBit), .counterValue(counterValue), .pwmDrive(pwmDrive), .counting(counting));
  tosm_ext_source src_u (.clk(clk), .wantLevel(want), .pwmClr(pwmClr), .pwmDrive(pwmDrive),
    .sigOut(sig), .pwmHigh(pwmHigh));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic set_run;
    runSet = 1;
    tick();
    runSet = 0;
    tick();
  endtask

  task automatic stop_run;
    runClr = 1;
    tick();
    runClr = 0;
    tick();
  endtask

  // Waits for the counting flag under a bound, then judges it.
  task automatic wait_cnt(input logic exp);
    int i;
    i = 0;
    while (counting !== exp && i < 40)
    begin
      tick();
      i++;
    end
    chk(counting, exp);
  endtask

  task automatic start(input logic lvl);
    want = lvl;
    tick();
    pwmClr = 0;
    wait_cnt(1);
  endtask

  // Counts the cycles of one run; optional extra edges land mid-run.
  task automatic finish(input logic toggles, input logic expRun);
    int n;
    n = 0;
    while (counting === 1 && n < 300)
    begin
      if (toggles && (n == 1 || n == 3))
        want = ~want;
      n++;
      tick();
    end
    chk(n[7:0], per + 8'h01);
    chk(counterValue, 8'h00);
    chk(runBit, expRun);
    chk(pwmHigh, pw + 8'h01);
    chk(pwmDrive, 0);
    pwmClr = 1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_oneshot(input tosm_mode_t m, input logic idle);
    mode = m;
    per = 8'h05;
    want = idle;
    tick(4);
    set_run;
    tick(8);
    chk(counting, 0);
    start(~idle);
    chk(pwmDrive, 1);
    finish(0, 0);
  endtask

  task automatic t_swstop;
    mode = `TOSM_MODE_OS_RISE;
    want = 0;
    tick(4);
    set_run;
    start(1);
    tick(2);
    stop_run;
    set_run;
    tick(8);
    chk(counting, 0);
    want = 0;
    tick(4);
    start(1);
    wait_cnt(0);
    chk(runBit, 0);
    pwmClr = 1;
  endtask

  // Edges with the run bit clear, then a start and a mid-run reset edge.
  task automatic t_hl(input tosm_mode_t m, input logic idle);
    int n;
    mode = m;
    per = 8'h14;
    want = idle;
    tick(4);
    want = ~idle;
    tick(4);
    want = idle;
    tick(6);
    chk(counting, 0);
    set_run;
    start(~idle);
    tick(8);
    chk(pwmDrive, 0);
    want = idle;
    tick(2);
    want = ~idle;
    wait_cnt(0);
    chk(counterValue, 8'h00);
    n = 0;
    while (counterValue === 8'h00 && n < 10)
    begin
      n++;
      tick();
    end
    chk(n[7:0], 8'h02);
    chk(pwmDrive, 1);
    wait_cnt(0);
    chk(runBit, 0);
    chk(counterValue, 8'h00);
    pwmClr = 1;
  endtask

  task automatic t_lr(input tosm_mode_t m, input logic rstLvl);
    mode = m;
    per = 8'h05;
    want = rstLvl;
    tick(4);
    set_run;
    tick(8);
    chk(counting, 0);
    start(~rstLvl);
    finish(0, 0);
    set_run;
    tick(8);
    chk(counting, 0);
    stop_run;
  endtask

  task automatic t_ms(input tosm_mode_t m, input logic idle);
    mode = m;
    per = 8'h08;
    want = idle;
    tick(4);
    set_run;
    start(~idle);
    finish(1, 1);
    tick(4);
    chk(counterValue, 8'h00);
    want = idle;
    tick(4);
    pwmClr = 0;
    chk(counting, m == `TOSM_MODE_MS_ANY);
    if (m != `TOSM_MODE_MS_ANY)
      start(~idle);
    finish(0, 1);
    stop_run;
  endtask

  // ----------------------------------------
  // Main sequence, watchdog and verdict
  // ----------------------------------------
  task automatic final_report;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    tick(10);
    rst = 0;
    tick();
    t_oneshot(`TOSM_MODE_OS_RISE, 0);
    t_oneshot(`TOSM_MODE_OS_FALL, 1);
    t_oneshot(`TOSM_MODE_OS_ANY, 1);
    t_swstop;
    t_hl(`TOSM_MODE_HL_RISE, 0);
    t_hl(`TOSM_MODE_HL_FALL, 1);
    t_lr(`TOSM_MODE_LR_LOW, 0);
    t_lr(`TOSM_MODE_LR_HIGH, 1);
    t_ms(`TOSM_MODE_MS_RISE, 0);
    t_ms(`TOSM_MODE_MS_FALL, 1);
    t_ms(`TOSM_MODE_MS_ANY, 0);
    final_report;
  end

  // The run needs well under 1500 cycles; twice that means a hang.
  initial
  begin
    #(100 * 3000);
    n_fail++;
    final_report;
  end
endmodule

// File: tb/tosm_ext_source.sv
// Purpose: Far-side model: external start/reset source and PWM input.
// Assumes: The bench asks for a level just after a rising edge.
// Notes: The line comes from a flop, as it would from other logic.
`timescale 1ns/1ns
module tosm_ext_source
(
  input wire logic clk, // Timer clock.
  input wire logic wantLevel, // Level asked for by the bench.
  input wire logic pwmClr, // Clears the high-time count.
  input wire logic pwmDrive, // Drive from the timer.
  output logic sigOut, // External start/reset line.
  output logic [7:0] pwmHigh // Cycles seen with drive high.
);
  // The line moves only on clock edges, so no edge is a glitch.
  // The PWM side counts high cycles, which shows any reassertion.
  always_ff @(posedge clk)
  begin
    sigOut <= wantLevel;
    pwmHigh <= pwmClr ? 8'h00 : pwmHigh + {7'h00, pwmDrive};
  end
endmodule

// File: verilog/tosm_edge_detect.sv
// Purpose: Synchronise the external start/reset signal and find its edges.
// Assumes: One clock; rst synchronous active high.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ns
module tosm_edge_detect
(
  input wire logic clk, // Timer clock.
  input wire logic rst, // Synchronous reset.
  input wire logic sigIn, // Raw external signal.
  output logic level, // Synchronised level.
  output logic rise, // One-cycle rising pulse.
  output logic fall // One-cycle falling pulse.
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  // Two-stage synchroniser, then one history stage for edge compare.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= sigIn;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // Each transition produces exactly one pulse.
  assign level = sync2_reg;
  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;
endmodule

// File: verilog/tosm_mode_decode.sv
// Purpose: Decode the mode field into class and edge selections.
// Assumes: Pure combinational.
// Notes: Unsupported codes decode to the idle class.
`timescale 1ns/1ns
`include "tosm_consts.svh"
module tosm_mode_decode
  import tosm_pkg::*;
(
  input tosm_pkg::tosm_mode_t mode, // Mode field.
  output tosm_pkg::tosm_cls_e cls, // Mode class.
  output logic useRise, // Rising edge qualifies.
  output logic useFall, // Falling edge qualifies.
  output logic resetHigh // Level-reset level is high.
);
  // Mode code table.
  always_comb
  begin
    cls = TOSM_CLS_NONE;
    useRise = 1'b0;
    useFall = 1'b0;
    resetHigh = 1'b0;
    case (mode)
      `TOSM_MODE_OS_RISE:
      begin
        cls = TOSM_CLS_OS;
        useRise = 1'b1;
      end
      `TOSM_MODE_OS_FALL:
      begin
        cls = TOSM_CLS_OS;
        useFall = 1'b1;
      end
      `TOSM_MODE_OS_ANY:
      begin
        cls = TOSM_CLS_OS;
        useRise = 1'b1;
        useFall = 1'b1;
      end
      `TOSM_MODE_HL_RISE:
      begin
        cls = TOSM_CLS_HL;
        useRise = 1'b1;
      end
      `TOSM_MODE_HL_FALL:
      begin
        cls = TOSM_CLS_HL;
        useFall = 1'b1;
      end
      `TOSM_MODE_LR_LOW:
      begin
        cls = TOSM_CLS_LR;
        useRise = 1'b1;
      end
      `TOSM_MODE_LR_HIGH:
      begin
        cls = TOSM_CLS_LR;
        useFall = 1'b1;
        resetHigh = 1'b1;
      end
      `TOSM_MODE_MS_RISE:
      begin
        cls = TOSM_CLS_MS;
        useRise = 1'b1;
      end
      `TOSM_MODE_MS_FALL:
      begin
        cls = TOSM_CLS_MS;
        useFall = 1'b1;
      end
      `TOSM_MODE_MS_ANY:
      begin
        cls = TOSM_CLS_MS;
        useRise = 1'b1;
        useFall = 1'b1;
      end
      default:
      begin
        cls = TOSM_CLS_NONE;
      end
    endcase
  end
endmodule

// File: verilog/tosm_timer.sv
// Purpose: Mode control of an 8-bit period timer, triggered one-shot modes.
// Assumes: Inputs synchronous to clk; clk is the selected timer clock.
// Notes: Software run-bit set and clear arrive as one-cycle pulses.
`timescale 1ns/1ns
`include "tosm_consts.svh"
module tosm_timer
  import tosm_pkg::*;
#(
  parameter int WIDTH = 8 // Counter width.
)
(
  input wire logic clk, // Timer clock, 10 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic runSet, // Software sets run bit, pulse.
  input wire logic runClr, // Software clears run bit, pulse.
  input tosm_pkg::tosm_mode_t mode, // Mode field.
  input wire logic [WIDTH-1:0] periodValue, // Period value.
  input wire logic [WIDTH-1:0] pulseWidthValue, // Pulse-width value.
  input wire logic extStartResetSignal, // External start/reset signal.
  output logic runBit, // Run bit state.
  output logic [WIDTH-1:0] counterValue, // Counter value.
  output logic pwmDrive, // Drive to the compare/PWM unit.
  output logic counting // Counter is advancing.
);
  import tosm_pkg::*;

  // ---------------------------------------------------------------
  // Decode and edge detection
  // ---------------------------------------------------------------
  tosm_cls_e cls;
  logic useRise;
  logic useFall;
  logic resetHigh;
  logic extLevel;
  logic extRise;
  logic extFall;

  tosm_mode_decode u_decode
  (
    .mode(mode),
    .cls(cls),
    .useRise(useRise),
    .useFall(useFall),
    .resetHigh(resetHigh)
  );

  tosm_edge_detect u_edge
  (
    .clk(clk),
    .rst(rst),
    .sigIn(extStartResetSignal),
    .level(extLevel),
    .rise(extRise),
    .fall(extFall)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic run_reg;
  logic run_next;
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic active_reg;
  logic active_next;
  logic started_reg;
  logic started_next;
  logic [1:0] delay_reg;
  logic [1:0] delay_next;
  logic pwm_reg;
  logic pwm_next;

  // Qualifying edge and the level-reset condition.
  wire qualEdge = (useRise & extRise) | (useFall & extFall);
  wire atResetLevel = (extLevel == resetHigh);
  wire periodMatch = active_reg & (delay_reg == 2'h0) & (count_reg == periodValue);
  wire pulseMatch = (count_reg == pulseWidthValue);
  wire runNow = (run_reg | runSet) & ~runClr;
  wire clsOs = (cls == TOSM_CLS_OS);
  wire clsHl = (cls == TOSM_CLS_HL);
  wire clsLr = (cls == TOSM_CLS_LR);
  wire clsMs = (cls == TOSM_CLS_MS);
  wire edgeTaken = run_reg & qualEdge;
  wire lrHold = clsLr & atResetLevel;

  // Next-state logic for all supported mode classes.
  always_comb
  begin
    run_next = runNow;
    count_next = count_reg;
    active_next = active_reg;
    started_next = started_reg;
    delay_next = delay_reg;
    pwm_next = pwm_reg;
    if (!run_reg)
    begin
      // Stopped: any start must come from a fresh edge after run is set again.
      active_next = 1'b0;
      started_next = 1'b0;
      delay_next = 2'h0;
    end
    else if (cls == TOSM_CLS_NONE)
    begin
      active_next = 1'b0;
    end
    else if (lrHold)
    begin
      // Counter held in reset while the signal sits at the reset level.
      count_next = `TOSM_COUNT_RESET;
      active_next = 1'b0;
    end
    else if (clsHl & started_reg & qualEdge)
    begin
      // Later edges reset the counter and restart after two clocks.
      count_next = `TOSM_COUNT_RESET;
      delay_next = 2'(`TOSM_RESTART_DELAY - 1);
      active_next = 1'b1;
      pwm_next = 1'b1;
    end
    else if (!active_reg & edgeTaken)
    begin
      // Starting edge begins counting and asserts the drive.
      active_next = 1'b1;
      started_next = 1'b1;
      pwm_next = 1'b1;
    end
    else if (active_reg & (delay_reg != 2'h0))
    begin
      delay_next = delay_reg - 2'h1;
    end
    else if (periodMatch)
    begin
      // Next clock after the match: counter to zero and stop.
      count_next = `TOSM_COUNT_RESET;
      active_next = 1'b0;
      pwm_next = 1'b0;
      if (clsOs | clsHl | clsLr)
      begin
        run_next = 1'b0;
      end
      else
      begin
        run_next = runNow;
      end
    end
    else if (active_reg)
    begin
      count_next = count_reg + 1'b1;
      if (pulseMatch)
      begin
        pwm_next = 1'b0;
      end
    end
    if (!clsMs & !clsLr & !clsHl & !clsOs)
    begin
      pwm_next = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Software stop keeps the count; a later edge resumes from there, except in level-reset modes, where the reset level zeroes it first.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      run_reg <= 1'b0;
      count_reg <= '0;
      active_reg <= 1'b0;
      started_reg <= 1'b0;
      delay_reg <= 2'h0;
      pwm_reg <= 1'b0;
    end
    else
    begin
      run_reg <= run_next;
      count_reg <= count_next;
      active_reg <= active_next;
      started_reg <= started_next;
      delay_reg <= delay_next;
      pwm_reg <= pwm_next;
    end
  end

  // Outputs straight from flip-flops.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      runBit <= 1'b0;
      counterValue <= '0;
      pwmDrive <= 1'b0;
      counting <= 1'b0;
    end
    else
    begin
      runBit <= run_next;
      counterValue <= count_next;
      pwmDrive <= pwm_next;
      counting <= active_next & (delay_next == 2'h0);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_os_idle;
    @(posedge clk) disable iff (rst)
    (run_reg & clsOs & !active_reg & !qualEdge & !runClr) |=> !active_reg;
  endproperty
  a_os_idle: assert property (p_os_idle) else $error("one-shot started without edge");

  property p_os_clear;
    @(posedge clk) disable iff (rst)
    (run_reg & periodMatch & clsOs & !qualEdge) |=> (!run_reg && count_reg == '0);
  endproperty
  a_os_clear: assert property (p_os_clear) else $error("one-shot run not cleared");

  property p_stop_idle;
    @(posedge clk) disable iff (rst)
    !run_reg |=> !active_reg;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("counting while run clear");

  property p_start_drive;
    @(posedge clk) disable iff (rst)
    (!active_reg & edgeTaken & !lrHold & !runClr) |=> (pwm_reg && active_reg);
  endproperty
  a_start_drive: assert property (p_start_drive) else $error("start edge missed");

  property p_hl_restart;
    @(posedge clk) disable iff (rst)
    (run_reg & clsHl & started_reg & qualEdge & !runClr) |=>
      (count_reg == '0 && delay_reg == 2'h1) ##1 (count_reg == '0);
  endproperty
  a_hl_restart: assert property (p_hl_restart) else $error("reset edge delay wrong");

  property p_hl_ignore;
    @(posedge clk) disable iff (rst)
    (!run_reg & clsHl) |=> !started_reg;
  endproperty
  a_hl_ignore: assert property (p_hl_ignore) else $error("edge used while run clear");

  property p_lr_hold;
    @(posedge clk) disable iff (rst)
    (run_reg & lrHold) |=> (count_reg == '0 && !active_reg);
  endproperty
  a_lr_hold: assert property (p_lr_hold) else $error("level reset not held");

  property p_ms_keep;
    @(posedge clk) disable iff (rst)
    (run_reg & periodMatch & clsMs & !runClr & !qualEdge) |=>
      (run_reg && count_reg == '0 && !pwm_reg);
  endproperty
  a_ms_keep: assert property (p_ms_keep) else $error("monostable stop wrong");

  property p_os_pulse;
    @(posedge clk) disable iff (rst)
    (run_reg & clsOs & active_reg & (delay_reg == 2'h0) & pulseMatch) |=> !pwm_reg;
  endproperty
  a_os_pulse: assert property (p_os_pulse) else $error("one-shot drive not ended");

  property p_sw_keep;
    @(posedge clk) disable iff (rst)
    !run_reg |=> $stable(count_reg);
  endproperty
  a_sw_keep: assert property (p_sw_keep) else $error("count moved while stopped");

  property p_hl_first;
    @(posedge clk) disable iff (rst)
    (run_reg & clsHl & !started_reg & !active_reg & qualEdge) |=>
      (started_reg && active_reg && pwm_reg);
  endproperty
  a_hl_first: assert property (p_hl_first) else $error("first edge did not start");

  property p_hl_clear;
    @(posedge clk) disable iff (rst)
    (run_reg & periodMatch & clsHl & !qualEdge) |=> (!run_reg && count_reg == '0);
  endproperty
  a_hl_clear: assert property (p_hl_clear) else $error("limit run not cleared");

  property p_hl_pulse;
    @(posedge clk) disable iff (rst)
    (run_reg & clsHl & active_reg & (delay_reg == 2'h0) & pulseMatch & !qualEdge) |=>
      !pwm_reg;
  endproperty
  a_hl_pulse: assert property (p_hl_pulse) else $error("limit drive not ended");

  property p_lr_clear;
    @(posedge clk) disable iff (rst)
    (run_reg & periodMatch & clsLr & !lrHold) |=> (!run_reg && count_reg == '0);
  endproperty
  a_lr_clear: assert property (p_lr_clear) else $error("level run not cleared");

  property p_lr_rearm;
    @(posedge clk) disable iff (rst)
    (run_reg & clsLr & !active_reg & !qualEdge) |=> !active_reg;
  endproperty
  a_lr_rearm: assert property (p_lr_rearm) else $error("level start without edge");

  property p_lr_pulse;
    @(posedge clk) disable iff (rst)
    (run_reg & clsLr & active_reg & !lrHold & (delay_reg == 2'h0) & pulseMatch) |=>
      !pwm_reg;
  endproperty
  a_lr_pulse: assert property (p_lr_pulse) else $error("level drive not ended");

  property p_ms_start;
    @(posedge clk) disable iff (rst)
    (run_reg & clsMs & !active_reg & qualEdge) |=> (active_reg && pwm_reg);
  endproperty
  a_ms_start: assert property (p_ms_start) else $error("monostable start missed");

  property p_ms_stop;
    @(posedge clk) disable iff (rst)
    (run_reg & clsMs & !active_reg & !qualEdge) |=> (!active_reg && $stable(count_reg));
  endproperty
  a_ms_stop: assert property (p_ms_stop) else $error("monostable moved idle");

  property p_ms_ignore;
    @(posedge clk) disable iff (rst)
    (run_reg & clsMs & active_reg & !pwm_reg & qualEdge) |=> !pwm_reg;
  endproperty
  a_ms_ignore: assert property (p_ms_ignore) else $error("extra edge drove pwm");

  c_os_done: cover property (@(posedge clk) disable iff (rst) periodMatch & clsOs);
  c_hl_reset: cover property (@(posedge clk) disable iff (rst) clsHl & started_reg & qualEdge);
  c_ms_done: cover property (@(posedge clk) disable iff (rst) periodMatch & clsMs);
  c_lr_done: cover property (@(posedge clk) disable iff (rst) periodMatch & clsLr);
  c_sw_stop: cover property (@(posedge clk) disable iff (rst) active_reg & runClr);
endmodule
